/* File: verilog/clfs_params.svh */
/*
 * Timing figures and selection codes for the current-limit fault sequencer.
 * Assumes a 100 MHz core clock; every count is derived from a time and the rate.
 */
`ifndef CLFS_PARAMS_SVH
`define CLFS_PARAMS_SVH

// Core clock rate in kHz
`define CLFS_CLK_KHZ 100000
// Startup blanking default, ms
`define CLFS_STARTUP_BLANK_MS 100
`define CLFS_STARTUP_BLANK_CYC (`CLFS_STARTUP_BLANK_MS * `CLFS_CLK_KHZ)
// Overcurrent blanking, ms (plain default)
`define CLFS_OC_BLANK_MS 10
`define CLFS_OC_BLANK_CYC (`CLFS_OC_BLANK_MS * `CLFS_CLK_KHZ)
// Retry delay, ms
`define CLFS_RETRY_MS 1000
`define CLFS_RETRY_CYC (`CLFS_RETRY_MS * `CLFS_CLK_KHZ)
// Fast-trip recovery delay, us
`define CLFS_FT_RECOVER_US 400
`define CLFS_FT_RECOVER_CYC (`CLFS_FT_RECOVER_US * `CLFS_CLK_KHZ / 1000)
// Reverse debounce, us (plain default)
`define CLFS_REV_DEB_US 100
`define CLFS_REV_DEB_CYC (`CLFS_REV_DEB_US * `CLFS_CLK_KHZ / 1000)
// Policy selection codes on the three-state pin decode
`define CLFS_SEL_LATCH 2'h1
`define CLFS_SEL_CONT 2'h0
`define CLFS_SEL_RETRY 2'h2

`endif

/* File: verilog/clfs_pkg.sv */
/*
 * Types for the current-limit fault sequencer.
 * Assumes clfs_params.svh supplies numeric constants.
 */
package clfs_pkg;
    // Current-limit policy
    typedef enum logic [1:0] {
        CLFS_CONT,
        CLFS_RETRY,
        CLFS_LATCH
    } clfs_policy_type;
    // Forward sequencer state
    typedef enum logic [2:0] {
        CLFS_OFF,
        CLFS_START,
        CLFS_RUN,
        CLFS_THERM,
        CLFS_RETRY_WAIT,
        CLFS_LATCHED
    } clfs_state_type;
endpackage

/* File: verilog/clfs_timer_if.sv */
/*
 * Interface carrying one interval timer's run request and expiry.
 * Assumes a single core clock shared by both ends.
 */
`timescale 1ns/1ps
interface clfs_timer_if;
    logic run;  // Count while high, clear when low
    logic done; // Interval reached
    modport ctl (output run, input done);
    modport tmr (input run, output done);
endinterface

/* File: verilog/clfs_timer.sv */
/*
 * Clocked interval counter: counts while run is high, clears when low.
 * Assumes synchronous run request from the sequencer.
 */
`timescale 1ns/1ps
module clfs_timer #(
    parameter int LEN = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Timer channel
    clfs_timer_if.tmr t
);
    localparam int W = $clog2(LEN + 1);
    logic [W-1:0] cnt; // Elapsed cycles

    // Count up, cleared whenever the governing condition ends
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
        end else if (!t.run) begin
            cnt <= '0; // R17
        end else if (cnt != W'(LEN)) begin
            cnt <= cnt + W'(1);
        end
    end

    // Saturates at the end so done stays up until run drops
    assign t.done = t.run && (cnt == W'(LEN));
endmodule

/* File: verilog/clfs_sequencer.sv */
/*
 * Current-limit fault sequencer top: policies, fast trip, slow reverse block.
 * Assumes comparator inputs are synchronous to core_clk and already filtered;
 * nrst follows power-on and enable, so toggling enable releases a latch.
 */
//
// Behaviour
// R1 - Continuous startup timeout: fault, keep output on
// R2 - Continuous thermal: fault, output off until cooled
// R3 - Continuous overcurrent past blank: fault, output on
// R4 - Retry startup overcurrent: output off, fault
// R5 - Retry delay after blank and cooling, restart
// R6 - Retry cycles repeat; clears when output reached
// R7 - Retry run overcurrent/thermal: off, fault, retry
// R8 - Latch startup overcurrent: output latched off
// R9 - Only enable or supply cycle clears latch
// R10 - Latch run overcurrent/thermal: latched off, fault
// R11 - Fast trip opens only the output switch
// R12 - Output back on after fixed recovery delay
// R13 - Reverse blocking only in blocking variant
// R14 - Debounced slow reverse opens input switch
// R15 - Three-state select chooses the policy
// R16 - Startup blanking behaves as continuous policy
// R17 - Intervals are clearing clocked counters
// R18 - Reverse cleared: input switch closes again
`timescale 1ns/1ps
`include "clfs_params.svh"
module clfs_sequencer import clfs_pkg::*; #(
    parameter int STARTUP_BLANK_CYC = `CLFS_STARTUP_BLANK_CYC,
    parameter int OC_BLANK_CYC = `CLFS_OC_BLANK_CYC,
    parameter int RETRY_CYC = `CLFS_RETRY_CYC,
    parameter int FT_RECOVER_CYC = `CLFS_FT_RECOVER_CYC,
    parameter int REV_DEB_CYC = `CLFS_REV_DEB_CYC,
    parameter bit REVERSE_BLOCKING = 1'b1
) (
    // Clock and reset (reset also from enable)
    input wire logic core_clk,
    input wire logic nrst,
    // Policy selection decode of the three-state pin
    input wire logic [1:0] limit_policy_select,
    // Comparator results
    input wire logic overcurrent,
    input wire logic fast_trip,
    input wire logic thermal_trip,
    input wire logic thermal_cooled,
    input wire logic output_good,
    input wire logic slow_reverse,
    // Switch controls
    output logic input_switch,
    output logic output_switch,
    // Open-drain fault pins: enable high pulls the pin low
    output logic forward_fault_n_oe,
    output logic reverse_fault_n_oe
);
    clfs_state_type state;        // Forward sequencer state
    clfs_policy_type policy;      // Decoded policy
    logic in_thermal;             // Thermal shutdown held until cooled
    logic ft_active;              // Fast-trip recovery in progress
    logic rev_blocked;            // Input switch opened by reverse
    logic fwd_fault;              // Forward fault level
    logic next_output_switch;     // Combined output switch demand

    // One channel per interval; each timer only counts, the sequencer decides
    clfs_timer_if st_if (); // Startup blanking
    clfs_timer_if oc_if (); // Overcurrent blanking in normal run
    clfs_timer_if rt_if (); // Retry delay
    clfs_timer_if ft_if (); // Fast-trip recovery
    clfs_timer_if rv_if (); // Slow reverse debounce

    // Startup blanking; the longest count but one, millions of cycles
    clfs_timer #(
        .LEN(STARTUP_BLANK_CYC)
    ) u_start (
        .core_clk(core_clk),
        .nrst(nrst),
        .t(st_if)
    );

    // Overcurrent blanking in normal operation
    clfs_timer #(
        .LEN(OC_BLANK_CYC)
    ) u_blank (
        .core_clk(core_clk),
        .nrst(nrst),
        .t(oc_if)
    );

    // Retry delay; widest counter in the block
    clfs_timer #(
        .LEN(RETRY_CYC)
    ) u_retry (
        .core_clk(core_clk),
        .nrst(nrst),
        .t(rt_if)
    );

    // Fast-trip recovery delay
    clfs_timer #(
        .LEN(FT_RECOVER_CYC)
    ) u_ftrec (
        .core_clk(core_clk),
        .nrst(nrst),
        .t(ft_if)
    );

    // Slow reverse debounce
    clfs_timer #(
        .LEN(REV_DEB_CYC)
    ) u_revdb (
        .core_clk(core_clk),
        .nrst(nrst),
        .t(rv_if)
    );

    // Policy decode; unknown code falls back to continuous as the mildest
    // The pin decode is taken as static; a change acts at the next decision
    always_comb begin
        unique case (limit_policy_select)
            `CLFS_SEL_LATCH: policy = CLFS_LATCH; // R15
            `CLFS_SEL_RETRY: policy = CLFS_RETRY; // R15
            default: policy = CLFS_CONT; // R15
        endcase
    end

    // Timer run requests; each ends, and clears, with its condition.
    // Done is formed from run inside the timer, so no request may read
    // its own done: that would close a combinational loop.
    // Startup blanking runs until the output is good or the state moves on
    assign st_if.run = (state == CLFS_START) && !output_good; // R17
    // Overcurrent blanking; a short overcurrent clears the count
    assign oc_if.run = (state == CLFS_RUN) && overcurrent; // R17
    // Retry delay holds at zero while thermal shutdown lasts
    assign rt_if.run = (state == CLFS_RETRY_WAIT) && !in_thermal; // R5
    // Recovery counts from the end of the trip, so a new trip restarts it
    assign ft_if.run = ft_active && !fast_trip; // R12 R17
    // Debounce; stops once the input switch has been opened
    assign rv_if.run = REVERSE_BLOCKING && slow_reverse && !rev_blocked; // R13 R17

    // Thermal shutdown holds until cooling by the hysteresis is seen
    // A fresh trip outranks a cooled report seen in the same cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            in_thermal <= 1'b0;
        end else if (thermal_trip) begin
            in_thermal <= 1'b1; // R2
        end else if (thermal_cooled) begin
            in_thermal <= 1'b0; // R2
        end
    end

    // Forward sequencer
    // Reset lands in startup: enable high means a fresh blanking interval
    // Latched is left only through nrst, which also carries the enable
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= CLFS_START;
        end else begin
            unique case (state)
                CLFS_START: begin
                    // Blanking acts as continuous policy until it ends
                    if (output_good) begin
                        state <= CLFS_RUN; // R4
                    end else if (thermal_trip) begin
                        state <= CLFS_THERM; // R16
                    end else if (st_if.done) begin
                        // Blanking expired: the policy decides from here
                        if (policy == CLFS_CONT) begin
                            state <= CLFS_RUN; // R1
                        end else if (policy == CLFS_RETRY) begin
                            state <= overcurrent ? CLFS_RETRY_WAIT : CLFS_RUN; // R4
                        end else begin
                            state <= overcurrent ? CLFS_LATCHED : CLFS_RUN; // R8
                        end
                    end
                end
                CLFS_RUN: begin
                    // Thermal has no blanking; overcurrent must last the interval
                    if (thermal_trip || oc_if.done) begin
                        unique case (policy)
                            CLFS_RETRY: state <= CLFS_RETRY_WAIT; // R7
                            CLFS_LATCH: state <= CLFS_LATCHED; // R10
                            default: state <= thermal_trip ? CLFS_THERM : CLFS_RUN; // R2 R3
                        endcase
                    end
                end
                CLFS_THERM: begin
                    // Continuous thermal off period, reached also from startup
                    if (!in_thermal && !thermal_trip) begin
                        state <= CLFS_RUN; // R2
                    end
                end
                CLFS_RETRY_WAIT: begin
                    // Switch stays open for the whole delay
                    if (rt_if.done) begin
                        state <= CLFS_START; // R5 R6
                    end
                end
                CLFS_LATCHED: begin
                    // Only reset leaves; every input is ignored here
                    state <= CLFS_LATCHED; // R9 R10
                end
                default: state <= CLFS_START;
            endcase
        end
    end

    // Forward fault level: set by timeouts and thermal trips, not by fast trip, cleared on output good.
    // Every set source outranks the clear, so a fault raised in the same
    // cycle as output good is never lost; retry and latch hold it up.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fwd_fault <= 1'b0;
        end else if (thermal_trip || in_thermal) begin
            fwd_fault <= 1'b1; // R2
        end else if ((state == CLFS_START) && st_if.done) begin
            fwd_fault <= 1'b1; // R1 R4 R8
        end else if (oc_if.done) begin
            fwd_fault <= 1'b1; // R3 R7 R10
        end else if (state == CLFS_LATCHED || state == CLFS_RETRY_WAIT) begin
            fwd_fault <= 1'b1; // R6
        end else if (output_good && !overcurrent) begin
            fwd_fault <= 1'b0; // R2 R6
        end
    end

    // Fast-trip recovery; a new trip while recovering restarts the delay
    // Output drops on the trip level itself, so the off path is one flop,
    // one core cycle, well inside the allowed microsecond
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ft_active <= 1'b0;
        end else if (fast_trip) begin
            ft_active <= 1'b1; // R11
        end else if (ft_if.done) begin
            ft_active <= 1'b0; // R12
        end
    end

    // Slow reverse: set wins over release in the same cycle
    // Without blocking the debounce never runs and the flag stays clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rev_blocked <= 1'b0;
        end else if (rv_if.done) begin
            rev_blocked <= 1'b1; // R14
        end else if (!slow_reverse || !REVERSE_BLOCKING) begin
            rev_blocked <= 1'b0; // R18 R13
        end
    end

    // Output switch demand from sequencer, thermal and fast trip
    // Any one off request wins; on is the default when nothing objects
    always_comb begin
        next_output_switch = 1'b1;
        if (state == CLFS_LATCHED || state == CLFS_RETRY_WAIT || state == CLFS_THERM) begin
            next_output_switch = 1'b0; // R2 R5 R8
        end
        if (in_thermal || thermal_trip) begin
            next_output_switch = 1'b0; // R2
        end
        if (fast_trip || ft_active) begin
            next_output_switch = 1'b0; // R11
        end
    end

    // Output switch register; top outputs come straight from flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            output_switch <= 1'b0; // Off during reset
        end else begin
            output_switch <= next_output_switch; // R1 R3
        end
    end

    // Input switch register; the debounce done opens it a cycle early
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            input_switch <= 1'b0; // Off during reset
        end else begin
            input_switch <= !(rev_blocked || rv_if.done); // R14 R18
        end
    end

    // Forward fault pin enable; high pulls the open-drain pin low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            forward_fault_n_oe <= 1'b0; // Released during reset
        end else begin
            forward_fault_n_oe <= fwd_fault;
        end
    end

    // Reverse fault pin enable, in step with the input switch
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reverse_fault_n_oe <= 1'b0; // Released during reset
        end else begin
            reverse_fault_n_oe <= rev_blocked || rv_if.done; // R14
        end
    end
endmodule

/* File: bench/clfs_sequencer_chk.sv */
/* Port checker for the fault sequencer.
   Assumes binding to every sequencer instance, single core clock. */
`timescale 1ns/1ps
module clfs_sequencer_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Watched inputs
    input wire logic [1:0] limit_policy_select,
    input wire logic fast_trip,
    input wire logic thermal_trip,
    input wire logic slow_reverse,
    // Watched outputs
    input wire logic input_switch,
    input wire logic output_switch,
    input wire logic reverse_fault_n_oe
);
    // One clock domain, so one default for all
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_ft_off;
        fast_trip |=> !output_switch;
    endproperty
    a_ft_off: assert property (p_ft_off) else $error("fast trip left output on");
    property p_ft_in;
        fast_trip && !slow_reverse && input_switch |=> input_switch;
    endproperty
    a_ft_in: assert property (p_ft_in) else $error("fast trip opened input");
    property p_ft_hold;
        $fell(fast_trip) |-> !output_switch [*3];
    endproperty
    a_ft_hold: assert property (p_ft_hold) else $error("no recovery delay");
    property p_rev_deb;
        $rose(slow_reverse) && !reverse_fault_n_oe |=> !reverse_fault_n_oe [*3];
    endproperty
    a_rev_deb: assert property (p_rev_deb) else $error("reverse not debounced");
    property p_rev_in;
        $rose(reverse_fault_n_oe) |-> !input_switch;
    endproperty
    a_rev_in: assert property (p_rev_in) else $error("reverse kept input on");
    property p_rev_clr;
        !slow_reverse [*3] |=> !reverse_fault_n_oe;
    endproperty
    a_rev_clr: assert property (p_rev_clr) else $error("reverse fault stuck");
    property p_cont_on;
        limit_policy_select == 2'h0 && output_switch && !thermal_trip && !fast_trip
            |=> output_switch;
    endproperty
    a_cont_on: assert property (p_cont_on) else $error("continuous opened output");
    // Thermal and fast trip excluded: they have their own release
    property p_retry_wait;
        $fell(output_switch) && limit_policy_select == 2'h2 && !$past(fast_trip)
            && !$past(thermal_trip) |-> !output_switch [*8];
    endproperty
    a_retry_wait: assert property (p_retry_wait) else $error("retry too soon");
endmodule
bind clfs_sequencer clfs_sequencer_chk clfs_sequencer_chk_inst (
    .core_clk(core_clk), .nrst(nrst), .limit_policy_select(limit_policy_select),
    .fast_trip(fast_trip), .thermal_trip(thermal_trip), .slow_reverse(slow_reverse),
    .input_switch(input_switch), .output_switch(output_switch),
    .reverse_fault_n_oe(reverse_fault_n_oe));

/* File: bench/clfs_sequencer_bench.sv */
/* Bench for the fault sequencer: drives comparator levels, checks switches.
   Assumes shortened intervals; outputs read as {in, out, fwd, rev}. */
`timescale 1ns/1ps
`include "clfs_params.svh"
module clfs_sequencer_bench;
    localparam int SB = 20; // Startup blank
    localparam int OB = 10; // Overcurrent blank
    localparam int RT = 30; // Retry delay
    localparam int FT = 8; // Fast-trip recovery
    localparam int RD = 5; // Reverse debounce
    logic core_clk, nrst, overcurrent, fast_trip, thermal_trip, thermal_cooled;
    logic output_good, slow_reverse, input_switch, output_switch;
    logic forward_fault_n_oe, reverse_fault_n_oe;
    logic [1:0] limit_policy_select;
    int err_total = 0;
    int samples_checked = 0;
    int n; // Random glitch length
    wire logic [3:0] obs = {input_switch, output_switch, forward_fault_n_oe, reverse_fault_n_oe};
    clfs_sequencer #(.STARTUP_BLANK_CYC(SB), .OC_BLANK_CYC(OB), .RETRY_CYC(RT),
        .FT_RECOVER_CYC(FT), .REV_DEB_CYC(RD)) clfs_sequencer_inst (
        .core_clk(core_clk), .nrst(nrst), .limit_policy_select(limit_policy_select),
        .overcurrent(overcurrent), .fast_trip(fast_trip), .thermal_trip(thermal_trip),
        .thermal_cooled(thermal_cooled), .output_good(output_good),
        .slow_reverse(slow_reverse), .input_switch(input_switch),
        .output_switch(output_switch), .forward_fault_n_oe(forward_fault_n_oe),
        .reverse_fault_n_oe(reverse_fault_n_oe));
    task automatic check(input logic [3:0] e);
        samples_checked++;
        if (obs !== e) begin
            err_total++;
            $display("[FAIL] %0t expected %b got %b", $time, e, obs);
        end
    endtask
    // Bounded wait for an expected output set
    task automatic reach(input logic [3:0] e, input int lim);
        for (int i = 0; i < lim && obs !== e; i++) begin
            @(posedge core_clk);
            #1;
        end
        check(e);
    endtask
    // Outputs must hold for a span
    task automatic stay(input logic [3:0] e, input int cyc);
        for (int i = 0; i < cyc && obs === e; i++) begin
            @(posedge core_clk);
            #1;
        end
        check(e);
    endtask
    // Levels {overcurrent, good, thermal, cooled, reverse}
    task automatic drive(input logic [4:0] v);
        @(posedge core_clk);
        {overcurrent, output_good, thermal_trip, thermal_cooled, slow_reverse} <= v;
    endtask
    // Reset doubles as the enable toggle that clears a latch
    task automatic rst(input logic [1:0] sel, input logic [4:0] v);
        @(posedge core_clk);
        nrst <= 1'b0;
        limit_policy_select <= sel;
        {overcurrent, output_good, thermal_trip, thermal_cooled, slow_reverse} <= v;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
    endtask
    task automatic conclude();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Watchdog, far beyond the few hundred cycles expected
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        conclude();
    end
    initial begin
        {nrst, overcurrent, fast_trip, thermal_trip, thermal_cooled, output_good} = '0;
        slow_reverse = 1'b0;
        limit_policy_select = `CLFS_SEL_CONT;
        void'($urandom(32'h53da939f));
        // Continuous startup never reaching target
        rst(`CLFS_SEL_CONT, 5'b10000);
        reach(4'b1100, 3);
        stay(4'b1100, SB - 6);
        reach(4'b1110, 8);
        drive(5'b01000);
        reach(4'b1100, 4);
        // Short overcurrent glitch, then a full one
        n = 1 + $urandom % (OB - 3);
        drive(5'b11000);
        repeat (n) @(posedge core_clk);
        drive(5'b01000);
        stay(4'b1100, OB + 3);
        drive(5'b11000);
        reach(4'b1110, OB + 4);
        drive(5'b01000);
        reach(4'b1100, 4);
        // One-cycle fast trip
        @(posedge core_clk);
        fast_trip <= 1'b1;
        @(posedge core_clk);
        fast_trip <= 1'b0;
        reach(4'b1000, 3);
        stay(4'b1000, FT - 3);
        reach(4'b1100, 6);
        // Continuous thermal, cooled before target
        drive(5'b00100);
        reach(4'b1010, 3);
        drive(5'b00010);
        reach(4'b1110, 4);
        drive(5'b01000);
        reach(4'b1100, 4);
        // Reverse glitch, then debounced reverse
        n = 1 + $urandom % (RD - 2);
        drive(5'b01001);
        repeat (n) @(posedge core_clk);
        drive(5'b01000);
        stay(4'b1100, RD + 3);
        drive(5'b01001);
        reach(4'b0101, RD + 4);
        drive(5'b01000);
        reach(4'b1100, 4);
        // Unused code falls back to continuous
        rst(2'h3, 5'b10000);
        reach(4'b1110, SB + 8);
        // Autoretry startup failure and recovery
        rst(`CLFS_SEL_RETRY, 5'b10000);
        reach(4'b1100, 3);
        reach(4'b1010, SB + 6);
        stay(4'b1010, RT - 4);
        reach(4'b1110, 8);
        drive(5'b01000);
        reach(4'b1100, SB + RT + 12);
        drive(5'b11000);
        reach(4'b1010, OB + 4);
        drive(5'b01000);
        stay(4'b1010, RT - 4);
        reach(4'b1100, 12);
        // Retry counts only after cooling
        drive(5'b01100);
        reach(4'b1010, 3);
        stay(4'b1010, 6);
        drive(5'b01010);
        stay(4'b1010, RT - 4);
        reach(4'b1100, 12);
        // Latch-off at startup, then in run
        rst(`CLFS_SEL_LATCH, 5'b10000);
        reach(4'b1100, 3);
        reach(4'b1010, SB + 6);
        drive(5'b01000);
        stay(4'b1010, RT + 10);
        rst(`CLFS_SEL_LATCH, 5'b01000);
        reach(4'b1100, 4);
        drive(5'b01100);
        reach(4'b1010, 3);
        drive(5'b01000);
        stay(4'b1010, RT);
        rst(`CLFS_SEL_LATCH, 5'b01000);
        reach(4'b1100, 4);
        drive(5'b11000);
        reach(4'b1010, OB + 4);
        drive(5'b01000);
        stay(4'b1010, 20);
        conclude();
    end
endmodule
